//--- design/ahb_reg_slave.sv
// ahb-lite slave turning single word transfers into register strobes
// assumes: single slave, hready is this slave's own hreadyout

`timescale 1ns/10ps
`include "irq_slice_cfg.svh"

module ahb_reg_slave (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // ahb-lite slave port
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // register side
   reg_bus_if.bus rbus
);
   import irq_slice_pkg::*;

   bus_state_t state;
   reg_ofs_t addr_q;
   logic take;

   // ==========================================================
   // address phase acceptance
   assign take = hsel && hready && htrans[`HTRANS_ACTIVE_BIT];

   // transfer state: reads pay one wait state so data come from a flop
   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE, ST_WRITE, ST_RDONE: begin
               if (take) begin
                  state <= hwrite ? ST_WRITE : ST_RWAIT;
               end else begin
                  state <= ST_IDLE;
               end
            end
            ST_RWAIT: begin
               state <= ST_RDONE;
            end
         endcase
      end
   end

   // address held for the data phase
   always_ff @(posedge mclk) begin
      if (reset) begin
         addr_q <= '0;
      end else if (take) begin
         addr_q <= haddr[`OFS_MSB:`OFS_LSB];
      end
   end

   // read data captured in the wait cycle, upper half reads zero
   always_ff @(posedge mclk) begin
      if (reset) begin
         hrdata <= '0;
      end else if (state == ST_RWAIT) begin
         hrdata <= {`WORD_ZERO, rbus.rdata};
      end
   end

   // ==========================================================
   // strobes to the register file
   assign rbus.wr = (state == ST_WRITE);
   assign rbus.rd = (state == ST_RWAIT);
   assign rbus.addr = addr_q;
   assign rbus.wdata = hwdata[15:0]; // upper half ignored
   assign hreadyout = (state != ST_RWAIT);
   assign hresp = `HRESP_OKAY;
endmodule // ahb_reg_slave

//--- design/interrupt_flag_priority_slice.sv
// interrupt flag status and second i2c priority slice with its bus slave
// assumes: event inputs are one-cycle pulses on mclk from peripherals,
// i2c pending levels come from a flag register kept elsewhere

`timescale 1ns/10ps
`include "irq_slice_cfg.svh"

// Functional notes
// RULE1: an implemented flag reads 1 while its request is pending.
// RULE2: an implemented flag reads 0 when nothing is pending.
// RULE3: second serial port error flag sits at bit 2.
// RULE4: first serial port error flag sits at bit 1.
// RULE5: unimplemented bits read zero and ignore writes.
// RULE6: i2c two master priority field is bits 10 to 8.
// RULE7: i2c two slave priority field is bits 6 to 4.
// RULE8: priority field value is the level, 1 lowest up to 7 highest.
// RULE9: a zero priority field disables the source entirely.
// RULE10: every priority field resets to level 4.
// RULE11: software clears a serviced flag by writing zero to it.
// RULE12: hardware event sets a flag until cleared; writing 1 sets it too.
module interrupt_flag_priority_slice (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // ahb-lite slave port
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // peripheral request pulses
   input wire logic charge_time_unit_event,
   input wire logic low_voltage_detect_event,
   input wire logic crc_generator_event,
   input wire logic serial_port_two_error_event,
   input wire logic serial_port_one_error_event,
   // second i2c port pending levels
   input wire logic i2c_two_master_pending,
   input wire logic i2c_two_slave_pending,
   // flag and request outputs to the core
   output irq_slice_pkg::reg_word_t pending_flag_registers,
   output logic i2c_two_master_request,
   output irq_slice_pkg::prio_t i2c_two_master_level,
   output logic i2c_two_slave_request,
   output irq_slice_pkg::prio_t i2c_two_slave_level,
   // interrupt line
   output logic irq
);
   import irq_slice_pkg::*;

   localparam reg_word_t flag_mask = `FLAG_MASK;

   reg_bus_if rbus ();

   reg_word_t pending_flags_group_a;
   reg_word_t event_status;
   reg_word_t event_enable;
   reg_word_t hw_event;
   prio_t i2c_two_master_event_priority;
   prio_t i2c_two_slave_event_priority;
   reg_sel_t sel;
   logic wr_pend;
   logic wr_prio;
   logic wr_clear;
   logic wr_enable;
   logic [1:0] gate_pending;
   prio_t gate_level [2];
   logic [1:0] gate_request;
   prio_t gate_out_level [2];

   // ==========================================================
   // address decode, shared by the write strobes and the read mux
   function automatic reg_sel_t decode(input reg_ofs_t ofs);
      unique case (ofs)
         `OFS_PENDING: decode = SEL_PEND;
         `OFS_PRIORITY: decode = SEL_PRIO;
         `OFS_EV_STATUS: decode = SEL_STAT;
         `OFS_EV_CLEAR: decode = SEL_CLR;
         `OFS_EV_ENABLE: decode = SEL_EN;
         default: decode = SEL_NONE;
      endcase
   endfunction

   // ==========================================================
   // bus slave
   ahb_reg_slave u_slave (
      .mclk(mclk),
      .reset(reset),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hwdata(hwdata),
      .hready(hready),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .rbus(rbus)
   );

   // write strobes per register; hsize is not checked, words only
   assign sel = decode(rbus.addr);
   assign wr_pend = rbus.wr && (sel == SEL_PEND);
   assign wr_prio = rbus.wr && (sel == SEL_PRIO);
   assign wr_clear = rbus.wr && (sel == SEL_CLR);
   assign wr_enable = rbus.wr && (sel == SEL_EN);

   // ==========================================================
   // peripheral pulses placed at their flag positions
   always_comb begin
      hw_event = `FLAG_RESET;
      hw_event[`BIT_CHARGE_TIME] = charge_time_unit_event;
      hw_event[`BIT_LOW_VOLTAGE] = low_voltage_detect_event;
      hw_event[`BIT_CRC_GEN] = crc_generator_event;
      hw_event[`BIT_SERIAL_TWO_ERR] = serial_port_two_error_event; // [RULE3]
      hw_event[`BIT_SERIAL_ONE_ERR] = serial_port_one_error_event; // [RULE4]
   end

   // ==========================================================
   // pending flags and event status, one flop per implemented bit
   for (genvar i = 0; i < 16; i++) begin : g_bit
      if (flag_mask[i]) begin : g_impl
         // event wins over a same-cycle software clear, so none is lost
         always_ff @(posedge mclk) begin
            if (reset) begin
               pending_flags_group_a[i] <= 1'b0; // [RULE2]
            end else if (hw_event[i]) begin
               pending_flags_group_a[i] <= 1'b1; // [RULE1] [RULE12]
            end else if (wr_pend) begin
               // zero clears a serviced flag, one sets it
               pending_flags_group_a[i] <= rbus.wdata[i]; // [RULE11] [RULE12]
            end
         end

         // sticky event status, write one to the clear register
         always_ff @(posedge mclk) begin
            if (reset) begin
               event_status[i] <= 1'b0;
            end else if (hw_event[i]) begin
               event_status[i] <= 1'b1;
            end else if (wr_clear && rbus.wdata[i]) begin
               event_status[i] <= 1'b0;
            end
         end

         // event enable, same layout as the status
         always_ff @(posedge mclk) begin
            if (reset) begin
               event_enable[i] <= 1'b0;
            end else if (wr_enable) begin
               event_enable[i] <= rbus.wdata[i];
            end
         end
      end else begin : g_unimpl
         assign pending_flags_group_a[i] = 1'b0; // [RULE5]
         assign event_status[i] = 1'b0; // [RULE5]
         assign event_enable[i] = 1'b0; // [RULE5]
      end
   end

   assign pending_flag_registers = pending_flags_group_a;

   // ==========================================================
   // priority fields of the second i2c port
   always_ff @(posedge mclk) begin
      if (reset) begin
         i2c_two_master_event_priority <= `PRIO_RESET; // [RULE10]
         i2c_two_slave_event_priority <= `PRIO_RESET; // [RULE10]
      end else if (wr_prio) begin
         // only the two fields store; every other bit is dropped
         i2c_two_master_event_priority <=
            rbus.wdata[`PRIO_MASTER_MSB:`PRIO_MASTER_LSB]; // [RULE6]
         i2c_two_slave_event_priority <=
            rbus.wdata[`PRIO_SLAVE_MSB:`PRIO_SLAVE_LSB]; // [RULE7]
      end
   end

   // ==========================================================
   // read mux; clear register is write only and reads zero
   always_comb begin
      rbus.rdata = `WORD_ZERO;
      unique case (sel)
         SEL_PEND: rbus.rdata = pending_flags_group_a; // [RULE1] [RULE2]
         SEL_PRIO: begin
            rbus.rdata[`PRIO_MASTER_MSB:`PRIO_MASTER_LSB] =
               i2c_two_master_event_priority; // [RULE6] [RULE5]
            rbus.rdata[`PRIO_SLAVE_MSB:`PRIO_SLAVE_LSB] =
               i2c_two_slave_event_priority; // [RULE7] [RULE5]
         end
         SEL_STAT: rbus.rdata = event_status;
         SEL_EN: rbus.rdata = event_enable;
         SEL_CLR: rbus.rdata = `WORD_ZERO;
         default: rbus.rdata = `WORD_ZERO; // unmapped offsets
      endcase
   end

   // ==========================================================
   // priority-gated requests, one per i2c event
   assign gate_pending = {i2c_two_slave_pending, i2c_two_master_pending};
   assign gate_level[0] = i2c_two_master_event_priority;
   assign gate_level[1] = i2c_two_slave_event_priority;

   for (genvar g = 0; g < 2; g++) begin : g_gate
      prio_request u_gate (
         .mclk(mclk),
         .reset(reset),
         .pending(gate_pending[g]),
         .level(gate_level[g]),
         .request(gate_request[g]),
         .req_level(gate_out_level[g])
      );
   end

   assign i2c_two_master_request = gate_request[0]; // [RULE9]
   assign i2c_two_master_level = gate_out_level[0]; // [RULE8]
   assign i2c_two_slave_request = gate_request[1]; // [RULE9]
   assign i2c_two_slave_level = gate_out_level[1]; // [RULE8]

   // ==========================================================
   // interrupt line, registered to keep the output glitch free
   always_ff @(posedge mclk) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(event_status & event_enable);
      end
   end
endmodule // interrupt_flag_priority_slice

//--- design/irq_slice_cfg.svh
// constants of the interrupt flag and priority slice
// assumes: included by bare name from every design file that needs it

`ifndef IRQ_SLICE_CFG_SVH
`define IRQ_SLICE_CFG_SVH

// ==========================================================
// register byte offsets on the ahb-lite bus
`define OFS_PENDING 8'h00
`define OFS_PRIORITY 8'h04
`define OFS_EV_STATUS 8'h08
`define OFS_EV_CLEAR 8'h0c
`define OFS_EV_ENABLE 8'h10
`define OFS_LSB 0
`define OFS_MSB 7

// ==========================================================
// pending flag positions, implemented mask and reset value
`define BIT_CHARGE_TIME 13
`define BIT_LOW_VOLTAGE 8
`define BIT_CRC_GEN 3
`define BIT_SERIAL_TWO_ERR 2
`define BIT_SERIAL_ONE_ERR 1
`define FLAG_MASK 16'h210e
`define FLAG_RESET 16'h0000

// ==========================================================
// priority fields, reset level and the disabled code
`define PRIO_MASTER_MSB 10
`define PRIO_MASTER_LSB 8
`define PRIO_SLAVE_MSB 6
`define PRIO_SLAVE_LSB 4
`define PRIO_RESET 3'h4
`define PRIO_OFF 3'h0

// ==========================================================
// bus details
`define WORD_ZERO 16'h0000
`define HTRANS_ACTIVE_BIT 1
`define HRESP_OKAY 1'h0

`endif

//--- design/irq_slice_pkg.sv
// types shared by the interrupt flag and priority slice
// assumes: compiled before every other design file

package irq_slice_pkg;

   // ==========================================================
   // data types
   typedef logic [15:0] reg_word_t;
   typedef logic [2:0] prio_t;
   typedef logic [7:0] reg_ofs_t;

   // ==========================================================
   // register select after address decode
   typedef enum logic [2:0] {
      SEL_PEND = 3'b000,
      SEL_PRIO = 3'b001,
      SEL_STAT = 3'b010,
      SEL_CLR = 3'b011,
      SEL_EN = 3'b100,
      SEL_NONE = 3'b111
   } reg_sel_t;

   // ==========================================================
   // ahb-lite slave transfer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WRITE = 2'b01,
      ST_RWAIT = 2'b10,
      ST_RDONE = 2'b11
   } bus_state_t;

endpackage

//--- design/prio_request.sv
// one priority-gated request toward the processor core
// assumes: pending level and priority are on the same clock

`timescale 1ns/10ps
`include "irq_slice_cfg.svh"

module prio_request (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // source and its priority field
   input wire logic pending,
   input wire irq_slice_pkg::prio_t level,
   // request to the core
   output logic request,
   output irq_slice_pkg::prio_t req_level
);
   import irq_slice_pkg::*;

   // ==========================================================
   // level zero masks the source even with its flag set
   always_ff @(posedge mclk) begin
      if (reset) begin
         request <= 1'b0;
      end else begin
         request <= pending && (level != `PRIO_OFF); // [RULE9]
      end
   end

   // field value is the level itself, 7 highest, 1 lowest
   always_ff @(posedge mclk) begin
      if (reset) begin
         req_level <= `PRIO_OFF;
      end else begin
         req_level <= level; // [RULE8]
      end
   end
endmodule // prio_request

//--- design/reg_bus_if.sv
// carrier between the ahb-lite slave and the register file
// assumes: both ends run on the same clock

`timescale 1ns/10ps

interface reg_bus_if;
   import irq_slice_pkg::*;

   logic wr;
   logic rd;
   reg_ofs_t addr;
   reg_word_t wdata;
   reg_word_t rdata;

   // ==========================================================
   // bus side drives strobes, register side answers with data
   modport bus (output wr, output rd, output addr, output wdata,
      input rdata);
   modport regs (input wr, input rd, input addr, input wdata,
      output rdata);
endinterface

//--- tb/interrupt_flag_priority_slice_test.sv
// self-checking bench for the interrupt flag and priority slice
// assumes: periph_model and the bound checker are compiled before it

`timescale 1ns/10ps
`include "irq_slice_cfg.svh"

module interrupt_flag_priority_slice_test;
   import irq_slice_pkg::*;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hready, hreadyout, hresp, i2c_m, i2c_s, m_req, s_req, irq;
   logic [31:0] hrdata, rd, rd_s;
   logic [4:0] events;
   reg_word_t pend;
   prio_t m_lvl, s_lvl;
   logic hr_s = 1'b0;
   int fails = 0;
   int num_checks = 0;
   int cycles = 0;

   // ==========================================================
   // clock, single slave so hready is its own hreadyout
   always #12.5 mclk = ~mclk;
   assign hready = hreadyout;

   interrupt_flag_priority_slice interrupt_flag_priority_slice_inst (
      .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .charge_time_unit_event(events[4]),
      .low_voltage_detect_event(events[3]),
      .crc_generator_event(events[2]),
      .serial_port_two_error_event(events[1]),
      .serial_port_one_error_event(events[0]),
      .i2c_two_master_pending(i2c_m), .i2c_two_slave_pending(i2c_s),
      .pending_flag_registers(pend), .i2c_two_master_request(m_req),
      .i2c_two_master_level(m_lvl), .i2c_two_slave_request(s_req),
      .i2c_two_slave_level(s_lvl), .irq(irq));

   periph_model periph_model_inst (
      .mclk(mclk), .events(events), .i2c_m(i2c_m), .i2c_s(i2c_s));

   // ==========================================================
   // bus helpers, values taken mid-cycle to avoid edge races
   always @(negedge mclk) begin
      hr_s <= hreadyout;
      rd_s <= hrdata;
   end

   task automatic bus_xfer(input logic [7:0] a, input logic w,
      input logic [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'b10;
      // an unknown ready must keep waiting, never pass as ready
      do @(posedge mclk); while (hr_s !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge mclk); while (hr_s !== 1'b1);
      rd = rd_s;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset();
      bus_xfer(`OFS_PRIORITY, 1'b0, 32'h0);
      chk("prio reset", 32'h00000440, rd);
      bus_xfer(`OFS_PENDING, 1'b0, 32'h0);
      chk("flags reset", 32'h0, rd);
      chk("master level", 32'h4, {29'h0, m_lvl});
      bus_xfer(8'h20, 1'b0, 32'h0);
      chk("unmapped", 32'h0, rd);
   endtask

   task automatic t_flags();
      int pos[5] = '{1, 2, 3, 8, 13};
      logic [15:0] e = 16'h0000;
      for (int i = 0; i < 5; i++) begin
         periph_model_inst.pulse(i);
         e = e | (16'h0001 << pos[i]);
         bus_xfer(`OFS_PENDING, 1'b0, 32'h0);
         chk("flag set", {16'h0, e}, rd);
      end
      chk("flag port", {16'h0, e}, {16'h0, pend});
      bus_xfer(`OFS_PENDING, 1'b1, 32'hffff0000);
      bus_xfer(`OFS_PENDING, 1'b0, 32'h0);
      chk("flag clear", 32'h0, rd);
      bus_xfer(`OFS_PENDING, 1'b1, 32'h0000ffff);
      bus_xfer(`OFS_PENDING, 1'b0, 32'h0);
      chk("flag soft set", 32'h0000210e, rd);
      bus_xfer(`OFS_PENDING, 1'b1, 32'h0);
   endtask

   // every level on both fields, junk in the reserved bits
   task automatic t_prio();
      logic [31:0] e;
      periph_model_inst.set_i2c(1'b1, 1'b1);
      for (int v = 0; v < 8; v++) begin
         e = (v << 8) | ((7 - v) << 4);
         bus_xfer(`OFS_PRIORITY, 1'b1, e | 32'hfffff88f);
         bus_xfer(`OFS_PRIORITY, 1'b0, 32'h0);
         chk("prio word", e, rd);
         chk("master level", v, {29'h0, m_lvl});
         chk("slave level", 7 - v, {29'h0, s_lvl});
         chk("master req", v != 0, {31'h0, m_req});
         chk("slave req", v != 7, {31'h0, s_req});
      end
      periph_model_inst.set_i2c(1'b0, 1'b0);
      repeat (2) @(posedge mclk);
      #1;
      chk("slave idle", 32'h0, {31'h0, s_req});
   endtask

   // enabled source raises irq, clear drops it, masked source stays quiet
   task automatic t_irq();
      // earlier flag tests left status bits set; start from a clean status
      bus_xfer(`OFS_EV_CLEAR, 1'b1, 32'h0000ffff);
      bus_xfer(`OFS_EV_STATUS, 1'b0, 32'h0);
      chk("status cleared", 32'h0, rd);
      bus_xfer(`OFS_EV_ENABLE, 1'b1, 32'h2);
      repeat (2) @(posedge mclk);
      #1;
      chk("irq idle", 32'h0, {31'h0, irq});
      periph_model_inst.pulse(0);
      repeat (2) @(posedge mclk);
      #1;
      chk("irq raised", 32'h1, {31'h0, irq});
      bus_xfer(`OFS_EV_CLEAR, 1'b1, 32'h2);
      repeat (2) @(posedge mclk);
      #1;
      chk("irq cleared", 32'h0, {31'h0, irq});
      periph_model_inst.pulse(1);
      repeat (2) @(posedge mclk);
      #1;
      chk("irq masked", 32'h0, {31'h0, irq});
      bus_xfer(`OFS_EV_STATUS, 1'b0, 32'h0);
      chk("status", 32'h4, rd);
   endtask

   // ==========================================================
   // hang guard and main sequence
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         end_of_test();
      end
   end

   initial begin
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      t_flags();
      t_prio();
      t_irq();
      // mid-run reset, held two edges so no flag drop is seen unmasked
      @(posedge mclk);
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      end_of_test();
   end
endmodule // interrupt_flag_priority_slice_test

//--- tb/irq_slice_sva.sv
// concurrent checks for the interrupt flag and priority slice
// assumes: sees only top ports, hready is fed back from hreadyout

`timescale 1ns/10ps

// ==========================================================
// checker module
module irq_slice_sva import irq_slice_pkg::*; (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // sources and outputs
   input wire logic crc_generator_event,
   input wire logic serial_port_two_error_event,
   input wire logic serial_port_one_error_event,
   input wire logic i2c_two_master_pending,
   input wire logic i2c_two_slave_pending,
   input wire irq_slice_pkg::reg_word_t pending_flag_registers,
   input wire logic i2c_two_master_request,
   input wire irq_slice_pkg::prio_t i2c_two_master_level,
   input wire logic i2c_two_slave_request
);
   wire logic go = hsel && hready && htrans[1];

   default clocking @(posedge mclk); endclocking
   default disable iff (reset);

   // bus handshake: one wait on reads, none on writes
   chk_read_wait: assert property (go && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait not one cycle");
   chk_write_nowait: assert property (go && hwrite |=> hreadyout)
      else $error("write stalled");
   chk_okay_resp: assert property (hresp == 1'b0)
      else $error("response not okay");
   // flag register layout and setting
   chk_unimpl_zero: assert property (
      (pending_flag_registers & ~16'h210e) == 16'h0000)
      else $error("unimplemented flag bit set");
   chk_crc_sets: assert property (
      crc_generator_event |=> pending_flag_registers[3])
      else $error("crc flag not set");
   chk_uart2_bit: assert property (
      serial_port_two_error_event |=> pending_flag_registers[2])
      else $error("serial two flag not at bit 2");
   chk_uart1_bit: assert property (
      serial_port_one_error_event |=> pending_flag_registers[1])
      else $error("serial one flag not at bit 1");
   // flag bit 1 only drops after a bus write two cycles before
   chk_flag_sticky: assert property (
      $fell(pending_flag_registers[1]) |-> $past(hwrite, 2) && $past(go, 2))
      else $error("flag dropped without a write");
   // priority gating of the second i2c requests
   chk_master_gate: assert property (
      i2c_two_master_request |-> i2c_two_master_level != 3'h0
      && $past(i2c_two_master_pending))
      else $error("master request while disabled or idle");
   chk_slave_idle: assert property (
      !i2c_two_slave_pending |=> !i2c_two_slave_request)
      else $error("slave request with nothing pending");
endmodule // irq_slice_sva

bind interrupt_flag_priority_slice irq_slice_sva irq_slice_sva_inst (
   .mclk(mclk), .reset(reset), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .crc_generator_event(crc_generator_event),
   .serial_port_two_error_event(serial_port_two_error_event),
   .serial_port_one_error_event(serial_port_one_error_event),
   .i2c_two_master_pending(i2c_two_master_pending),
   .i2c_two_slave_pending(i2c_two_slave_pending),
   .pending_flag_registers(pending_flag_registers),
   .i2c_two_master_request(i2c_two_master_request),
   .i2c_two_master_level(i2c_two_master_level),
   .i2c_two_slave_request(i2c_two_slave_request));

//--- tb/periph_model.sv
// model of the interrupting peripherals facing the slice
// assumes: same clock as the slice, driven by bench task calls

`timescale 1ns/10ps

// ==========================================================
// peripheral sources
module periph_model (
   // clock
   input wire logic mclk,
   // request pulses, 4 charge, 3 voltage, 2 crc, 1 serial two, 0 one
   output logic [4:0] events,
   // second i2c pending levels
   output logic i2c_m,
   output logic i2c_s
);
   initial begin
      events = 5'h00;
      i2c_m = 1'b0;
      i2c_s = 1'b0;
   end

   // one-cycle pulse, a held level would keep setting the flag
   task automatic pulse(input int idx);
      @(posedge mclk);
      events[idx] <= 1'b1;
      @(posedge mclk);
      events <= 5'h00;
   endtask

   // pending levels change just after an edge
   task automatic set_i2c(input logic m, input logic s);
      @(posedge mclk);
      i2c_m <= m;
      i2c_s <= s;
   endtask
endmodule // periph_model
